// *** fti_pkg.sv ***
// constants for the buffer trigger select and interrupt status block
package fti_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FTI_OFS_TRIG_SELECT = 8'h0A;
  localparam logic [7:0] FTI_OFS_SYS_MODE    = 8'h0B;
  localparam logic [7:0] FTI_OFS_INT_SOURCE  = 8'h0C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FTI_TRIG_LSB        = 2;      // fall/motion, then tap, orientation, transient
  localparam int         FTI_TRIG_W          = 4;
  localparam logic [3:0] FTI_TRIG_RESET      = 4'h0;
  localparam int         FTI_MODE_LSB        = 0;
  localparam int         FTI_COUNT_LSB       = 2;
  localparam int         FTI_COUNT_W         = 5;
  localparam int         FTI_GERR_BIT        = 7;
  localparam logic [4:0] FTI_COUNT_RESET     = 5'h00;
  localparam logic [4:0] FTI_COUNT_MAX       = 5'h1F;
  localparam int         FTI_SRC_SLEEP_WAKE  = 7;
  localparam int         FTI_SRC_BUFFER      = 6;
  localparam int         FTI_SRC_TRANSIENT   = 5;
  localparam int         FTI_SRC_ORIENT      = 4;
  localparam int         FTI_SRC_TAP         = 3;
  localparam int         FTI_SRC_FALL        = 2;
  localparam int         FTI_SRC_READY       = 0;
  localparam logic [7:0] FTI_SRC_USED        = 8'hFD;  // bit 1 is unused
  localparam logic [7:0] FTI_DATA_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // operating mode codes and the all-axes read mask
  // ----------------------------------------------------------------
  localparam logic [1:0] FTI_MODE_STANDBY    = 2'h0;
  localparam logic [1:0] FTI_MODE_WAKE       = 2'h1;
  localparam logic [1:0] FTI_MODE_SLEEP      = 2'h2;
  localparam logic [2:0] FTI_AXES_ALL        = 3'h7;
endpackage

// *** fti_edge_flags.sv ***
// sticky flags set by rising edges of level inputs and cleared by pulses
`timescale 1ns/1ns
module fti_edge_flags #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] clear,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] flag,
  output logic      [W-1:0] rise
);
  logic [W-1:0] prev;
  logic [W-1:0] next_flag;

  // ----------------------------------------------------------------
  // edge detect and set-over-clear
  // ----------------------------------------------------------------
  always_comb begin
    rise      = level & ~prev;                       // low-to-high only
    next_flag = (flag & ~clear) | (rise & enable);   // a new edge beats the clear
  end

  // register the flags and the previous levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
      flag <= '0;
    end else begin
      prev <= level;
      flag <= next_flag;
    end
  end
endmodule

// *** fti_status_core.sv ***
// trigger select, system mode and interrupt source registers
`timescale 1ns/1ns
// How it works
// - a read/write select register holds transient in bit 5, orientation 4, tap 3 and fall/motion 2, all 0 at reset.
// - a trigger indication is set only by a low-to-high change of its function interrupt, never by a steady level.
// - a trigger indication clears when the host reads the source register of the function that raised it.
// - only a function whose select bit is 1 can trigger the sample buffer, and a 0 indication means no trigger.
// - bits 1 to 0 of the system mode register show the mode: 00 standby at reset, 01 wake, 10 sleep.
// - bit 7 of the system mode register is the gate error flag, 0 at reset and 1 once an error is seen.
// - only emptying the sample buffer clears the gate error flag.
// - bits 6 to 2 count sample periods since the gate error flag rose, starting at zero and zeroed when it clears.
// - the source register holds sleep/wake in 7, buffer 6, transient 5, orientation 4, tap 3, fall/motion 2, ready 0.
// - a source bit reads 1 while its function has raised an interrupt and 0 otherwise.
// - source bits set on a rising event and clear only on the read that belongs to their own function, never on a read of this register.
// - the ready source bit clears only after all three axis high bytes were read, not on a status read.
// - reading the system mode register clears the sleep/wake source bit.
// - reading the buffer status register clears the buffer source bit, which sets again on the next buffer event.
module fti_status_core
  import fti_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] op_mode,
  input  wire logic       transient_event,
  input  wire logic       orientation_event,
  input  wire logic       tap_event,
  input  wire logic       fall_motion_event,
  input  wire logic       axes_ready_flag,
  input  wire logic       buffer_event,
  input  wire logic       sleep_wake_event,
  input  wire logic       transient_src_read,
  input  wire logic       orientation_src_read,
  input  wire logic       tap_src_read,
  input  wire logic       fall_motion_src_read,
  input  wire logic       buffer_status_read,
  input  wire logic [2:0] axis_high_read,
  input  wire logic       gate_error_detect,
  input  wire logic       buffer_emptied,
  input  wire logic       output_sample_rate,
  output logic            buffer_trigger,
  output logic      [3:0] trigger_pending,
  output logic      [7:0] interrupt_source
);
  logic [3:0]  trigger_select;
  logic [1:0]  mode;
  logic        gate_error_flag;
  logic [4:0]  gate_error_period_count;
  logic [2:0]  axes_seen;
  logic [3:0]  next_trigger_select;
  logic [1:0]  next_mode;
  logic        next_gate_error_flag;
  logic [4:0]  next_gate_error_period_count;
  logic [2:0]  next_axes_seen;
  logic [7:0]  next_reg_rdata;
  logic        next_buffer_trigger;
  logic        ready_clear;
  logic        mode_read;
  logic [3:0]  func_level;
  logic [3:0]  func_clear;
  logic [3:0]  func_rise;
  logic [7:0]  src_level;
  logic [7:0]  src_clear;
  logic [7:0]  src_rise;

  // ----------------------------------------------------------------
  // event vectors in register bit order
  // ----------------------------------------------------------------
  assign func_level = {transient_event, orientation_event, tap_event, fall_motion_event};
  assign func_clear = {transient_src_read, orientation_src_read, tap_src_read, fall_motion_src_read};
  assign mode_read  = reg_rd && (reg_addr == FTI_OFS_SYS_MODE);
  assign src_level  = {sleep_wake_event, buffer_event, func_level, 1'b0, axes_ready_flag};
  assign src_clear  = {mode_read, buffer_status_read, func_clear, 1'b0, ready_clear};

  // trigger indications, one per selectable function
  fti_edge_flags #(
    .W (FTI_TRIG_W)
  ) u_trig (
    .sys_clk (sys_clk),
    .rst     (rst),
    .level   (func_level),
    .clear   (func_clear),
    .enable  (trigger_select),
    .flag    (trigger_pending),
    .rise    (func_rise)
  );

  // interrupt source bits
  fti_edge_flags #(
    .W (8)
  ) u_src (
    .sys_clk (sys_clk),
    .rst     (rst),
    .level   (src_level),
    .clear   (src_clear),
    .enable  (FTI_SRC_USED),
    .flag    (interrupt_source),
    .rise    (src_rise)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_trigger_select = trigger_select;
    if (reg_wr && reg_addr == FTI_OFS_TRIG_SELECT) begin
      next_trigger_select = reg_wdata[FTI_TRIG_LSB +: FTI_TRIG_W];
    end
    next_buffer_trigger = |(func_rise & trigger_select);
    next_mode = op_mode;
    // ready bit waits for all three axis high-byte reads
    next_axes_seen = axes_seen | axis_high_read;
    ready_clear    = (next_axes_seen == FTI_AXES_ALL);
    if (ready_clear) begin
      next_axes_seen = 3'h0;
    end
    // gate error: detection wins over an empty in the same cycle
    next_gate_error_flag         = gate_error_flag;
    next_gate_error_period_count = gate_error_period_count;
    if (gate_error_detect) begin
      next_gate_error_flag = 1'b1;
    end else if (buffer_emptied) begin
      next_gate_error_flag = 1'b0;
    end
    if (!next_gate_error_flag) begin
      next_gate_error_period_count = FTI_COUNT_RESET;
    end else if (gate_error_flag && output_sample_rate
                 && gate_error_period_count != FTI_COUNT_MAX) begin
      next_gate_error_period_count = gate_error_period_count + 5'h01;
    end
    // read data, unmapped offsets read as zero
    next_reg_rdata = FTI_DATA_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        FTI_OFS_TRIG_SELECT: next_reg_rdata = {2'h0, trigger_select, 2'h0};
        FTI_OFS_SYS_MODE:    next_reg_rdata = {gate_error_flag, gate_error_period_count, mode};
        FTI_OFS_INT_SOURCE:  next_reg_rdata = interrupt_source;
        default:             next_reg_rdata = FTI_DATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigger_select          <= FTI_TRIG_RESET;
      mode                    <= FTI_MODE_STANDBY;
      gate_error_flag         <= 1'b0;
      gate_error_period_count <= FTI_COUNT_RESET;
      axes_seen               <= 3'h0;
      reg_rdata               <= FTI_DATA_ZERO;
      buffer_trigger          <= 1'b0;
    end else begin
      trigger_select          <= next_trigger_select;
      mode                    <= next_mode;
      gate_error_flag         <= next_gate_error_flag;
      gate_error_period_count <= next_gate_error_period_count;
      axes_seen               <= next_axes_seen;
      reg_rdata               <= next_reg_rdata;
      buffer_trigger          <= next_buffer_trigger;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CFG_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == FTI_OFS_TRIG_SELECT |=> trigger_select == $past(reg_wdata[5:2]))
    else $error("trigger select did not take the write");
  AST_TRIG_ONLY_SELECTED: assert property (@(posedge sys_clk) disable iff (rst)
    !(|({$rose(transient_event), $rose(orientation_event), $rose(tap_event), $rose(fall_motion_event)}
        & trigger_select)) |=> !buffer_trigger)
    else $error("buffer trigger without a selected rising edge");
  AST_TRIG_FIRES: assert property (@(posedge sys_clk) disable iff (rst)
    |({$rose(transient_event), $rose(orientation_event), $rose(tap_event), $rose(fall_motion_event)}
      & trigger_select) |=> buffer_trigger)
    else $error("selected rising edge did not trigger the buffer");
  AST_TRIG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    tap_src_read && !$rose(tap_event) |=> !trigger_pending[1])
    else $error("trigger indication survived its source read");
  AST_MODE_READ: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == FTI_OFS_SYS_MODE |=> reg_rdata[1:0] == $past(op_mode, 2))
    else $error("mode field does not follow the operating mode");
  AST_SUMMARY_NO_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == FTI_OFS_INT_SOURCE && src_clear == 8'h00
    |=> (interrupt_source & $past(interrupt_source)) == $past(interrupt_source))
    else $error("summary register read cleared a source bit");
  AST_GERR_COUNT_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    !gate_error_flag |-> gate_error_period_count == 5'h00)
    else $error("gate error count nonzero without the flag");
  AST_TRIG_LEVEL_NO_SET: assert property (@(posedge sys_clk) disable iff (rst)
    !trigger_pending[0] && $past(fall_motion_event) && fall_motion_event |=> !trigger_pending[0])
    else $error("trigger indication set by a steady level");
  AST_GERR_SET: assert property (@(posedge sys_clk) disable iff (rst)
    gate_error_detect |=> gate_error_flag && gate_error_period_count == 5'h00 || $past(gate_error_flag))
    else $error("gate error flag not set after detection");
  AST_GERR_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    gate_error_flag && !buffer_emptied |=> gate_error_flag)
    else $error("gate error flag cleared without an empty buffer");
  AST_GERR_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    buffer_emptied && !gate_error_detect |=> !gate_error_flag && gate_error_period_count == 5'h00)
    else $error("gate error not cleared with its count");
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (rst)
    gate_error_flag && output_sample_rate && !buffer_emptied
    |=> gate_error_period_count == (($past(gate_error_period_count) == 5'h1F) ? 5'h1F
                                    : $past(gate_error_period_count) + 5'h01))
    else $error("gate error period count stepped wrongly");
  AST_READY_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    interrupt_source[0] && axis_high_read == 3'h0 && axes_seen != 3'h7 ##1 axis_high_read == 3'h0
    |=> interrupt_source[0])
    else $error("ready source bit cleared without all axis reads");
  AST_SLEEP_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    mode_read && !src_rise[7] |=> !interrupt_source[7])
    else $error("sleep/wake source bit survived a mode register read");
  AST_BUFFER_SET: assert property (@(posedge sys_clk) disable iff (rst)
    src_rise[6] |=> interrupt_source[6])
    else $error("buffer source bit lost a new event");
endmodule

// *** fti_host_model.sv ***
// host processor model driving the register strobe port
`timescale 1ns/1ns
module fti_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe, read data taken the cycle after; stale address and data inverted
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
    #1 q = reg_rdata;
  endtask
  // poll the mode register to follow mode changes
  task automatic poll_mode(output logic [7:0] q);
    access(1'b0, 8'h0B, 8'h00, q);
  endtask
endmodule

// *** fifo_trigger_and_interrupt_status_tb.sv ***
// self-checking bench for the trigger select and interrupt status block
`timescale 1ns/1ns
module fifo_trigger_and_interrupt_status_tb;
  import fti_pkg::*;
  logic       sys_clk, rst, reg_wr, reg_rd, bsr, ged, bem, osr, buffer_trigger;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, interrupt_source, q;
  logic [6:0] ev;  // 0 fall, 1 tap, 2 orient, 3 transient, 4 ready, 5 buffer, 6 sleep
  logic [3:0] srd, trigger_pending;
  logic [2:0] ahr;
  logic [1:0] op_mode;
  logic [31:0] seed;
  int         n_mismatch, tests_run;
  fti_host_model HOST (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  fti_status_core DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_mode(op_mode), .transient_event(ev[3]),
    .orientation_event(ev[2]), .tap_event(ev[1]), .fall_motion_event(ev[0]), .axes_ready_flag(ev[4]),
    .buffer_event(ev[5]), .sleep_wake_event(ev[6]), .transient_src_read(srd[3]), .orientation_src_read(srd[2]),
    .tap_src_read(srd[1]), .fall_motion_src_read(srd[0]), .buffer_status_read(bsr), .axis_high_read(ahr),
    .gate_error_detect(ged), .buffer_emptied(bem), .output_sample_rate(osr), .buffer_trigger(buffer_trigger),
    .trigger_pending(trigger_pending), .interrupt_source(interrupt_source));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] src_of(input logic [6:0] e);
    return {e[6], e[5], e[3:0], 1'b0, e[4]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one-cycle pulse on the clear and period inputs, then sample settled outputs
  task automatic strobe(input logic [3:0] s, input logic b, input logic [2:0] a, input logic g, input logic m,
                        input logic o);
    @(posedge sys_clk);
    {srd, bsr, ahr, ged, bem, osr} <= {s, b, a, g, m, o};
    @(posedge sys_clk);
    {srd, bsr, ahr, ged, bem, osr} <= 11'h000;
    #1;
  endtask
  // ------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {rst, op_mode, ev, srd, bsr, ahr, ged, bem, osr} = 21'h10_0000;
    n_mismatch = 0;
    tests_run = 0;
    seed = 32'h8bab;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 10; a < 14; a++) begin
      HOST.access(1'b0, 8'(a), 8'h00, q);
      check(q, FTI_DATA_ZERO);
    end
    HOST.access(1'b1, FTI_OFS_SYS_MODE, 8'hFF, q);
    HOST.poll_mode(q);
    check(q, 8'h00);
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      op_mode <= 2'(m);
      HOST.poll_mode(q);
      check(q, 8'(m));
    end
    op_mode <= FTI_MODE_STANDBY;
    repeat (6) begin
      seed = lfsr(seed);
      HOST.access(1'b1, FTI_OFS_TRIG_SELECT, seed[15:8], q);
      @(posedge sys_clk);
      ev <= seed[6:0];
      @(posedge sys_clk);
      ev <= 7'h00;
      #1 check(interrupt_source, src_of(seed[6:0]));
      check({3'h0, buffer_trigger, trigger_pending}, {3'h0, |(seed[3:0] & seed[13:10]), seed[3:0] & seed[13:10]});
      HOST.access(1'b0, FTI_OFS_TRIG_SELECT, 8'h00, q);
      check(q, seed[15:8] & 8'h3C);
      HOST.access(1'b0, FTI_OFS_INT_SOURCE, 8'h00, q);
      check(q, src_of(seed[6:0]));
      strobe(4'hF, 1'b1, FTI_AXES_ALL, 1'b0, 1'b0, 1'b0);
      HOST.poll_mode(q);
      check(interrupt_source, 8'h00);
      check({4'h0, trigger_pending}, 8'h00);
    end
    HOST.access(1'b1, FTI_OFS_TRIG_SELECT, 8'h08, q);
    @(posedge sys_clk);
    ev <= 7'h23;
    @(posedge sys_clk);
    #1 check({3'h0, buffer_trigger, trigger_pending}, 8'h12);
    repeat (3) @(posedge sys_clk);
    #1 check({3'h0, buffer_trigger, trigger_pending}, 8'h02);
    strobe(4'h2, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
    check({trigger_pending, interrupt_source[3:0]}, 8'h04);
    strobe(4'h0, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
    check(interrupt_source, 8'h04);
    @(posedge sys_clk);
    ev <= 7'h53;  // buffer level drops, ready and sleep/wake rise
    strobe(4'h0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0);
    ev <= 7'h73;  // buffer level rises again after its clear
    HOST.access(1'b0, 8'h00, 8'h00, q);
    check(interrupt_source, 8'hC5);
    HOST.poll_mode(q);
    check(interrupt_source, 8'h45);
    strobe(4'h0, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0);
    check(interrupt_source, 8'h44);
    strobe(4'h0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0);
    HOST.poll_mode(q);
    check(q, 8'h80);
    repeat (3) strobe(4'h0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
    HOST.poll_mode(q);
    check(q, 8'h8C);
    repeat (40) strobe(4'h0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
    HOST.poll_mode(q);
    check(q, 8'hFC);
    strobe(4'h0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0);
    HOST.poll_mode(q);
    check(q, 8'h00);
    report_and_stop();
  end
endmodule
